/* logic/pid_control_block.sv */
// Closed-loop PID controller with a word register port and selectable target and feedback sources.
// Assumes source values, minima and maxima come from logic on the same clock.
`timescale 1ns/1ps
`include "pid_defs.svh"

// Summary of operation
// - While active, one controller iteration runs each time the loop period in milliseconds elapses.
// - The response profile field decodes 0 single output, 1 setpoint, 2 on over target, 3 on below target.
// - Target and feedback are converted to percentages of the minimum to maximum range of their source.
// - In single output profile target and feedback may differ in units since only percentages are compared.
// - In single output profile the output is confined to minus one hundred to plus one hundred percent.
// - A non-zero deadband forces an error whose magnitude lies below it to zero in every term.
// - The error is the target percentage minus the feedback percentage.
// - The error sum adds each error to the previous sum, and the integral term is integral gain times it.
// - The output is proportional plus integral plus derivative gain times the change of error.
// - Proportional gain is the overall gain; integral gain is gain times factor times period over time, or zero.
// - Derivative gain is gain times factor times derivative time over the period in milliseconds.
// - An output whose control source selects this controller is driven from its command.
// - Target and feedback are each chosen by a source type and instance number pair.

module pid_control_block #(
	parameter int N_TYPES    = 4,
	parameter int N_INST     = 4,
	parameter int DATA_W     = 16,
	parameter int INSTANCE   = 0,
	parameter int PID_TYPE   = 5,
	parameter int CYC_PER_MS = `PID_MS_NS / `PID_CLK_PERIOD_NS
) (
	input  wire logic                              i_clk,
	input  wire logic                              i_resetn,
	input  wire logic [7:0]                        i_addr,
	input  wire logic [31:0]                       i_wdata,
	input  wire logic                              i_wr,
	input  wire logic                              i_rd,
	output logic      [31:0]                       o_rdata,
	input  wire logic [N_TYPES*N_INST*DATA_W-1:0]  i_src_value,
	input  wire logic [N_TYPES*N_INST*DATA_W-1:0]  i_src_min,
	input  wire logic [N_TYPES*N_INST*DATA_W-1:0]  i_src_max,
	output logic signed [15:0]                     o_cmd,
	output logic                                   o_cmd_valid,
	output logic signed [15:0]                     o_out_drive,
	output logic                                   o_out_selected
);

	localparam int N_SRC = N_TYPES * N_INST;
	localparam logic signed [63:0] PCT_HI = 64'(`PID_PCT_FULL);
	localparam logic signed [63:0] PCT_LO = -PCT_HI;

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic [DATA_W-1:0]     vals [N_SRC];
	logic [DATA_W-1:0]     mins [N_SRC];
	logic [DATA_W-1:0]     maxs [N_SRC];
	logic                  active_r;
	logic                  active_d_r;
	pid_pkg::profile_t     profile_r;
	logic [15:0]           loop_r;
	logic [15:0]           gain_r;
	logic [15:0]           ifact_r;
	logic [15:0]           itime_r;
	logic [15:0]           dfact_r;
	logic [15:0]           dtime_r;
	logic [15:0]           dband_r;
	logic [7:0]            tsel_r;
	logic [7:0]            fsel_r;
	logic [7:0]            osel_r;
	logic [31:0]           rdata_r;
	logic [31:0]           cyc_r;
	logic [15:0]           ms_r;
	logic                  go;
	pid_pkg::state_t       state_r;
	logic [1:0]            step_r;
	logic [15:0]           tpct_r;
	logic [15:0]           fpct_r;
	logic [31:0]           ig_r;
	logic [31:0]           dg_r;
	logic signed [23:0]    acc_r;
	logic signed [16:0]    prev_err_r;
	logic signed [15:0]    cmd_r;
	logic                  valid_r;
	logic [15:0]           iter_r;
	logic signed [15:0]    drive_r;
	logic                  sel_r;
	logic [47:0]           op_num;
	logic [15:0]           op_den;
	logic signed [16:0]    err_raw;
	logic [16:0]           err_abs;
	logic signed [16:0]    err_k;
	logic signed [24:0]    acc_sum;
	logic signed [23:0]    acc_nxt;
	logic signed [63:0]    p_term;
	logic signed [63:0]    i_term;
	logic signed [63:0]    d_term;
	logic signed [63:0]    sum;
	logic signed [15:0]    cmd_nxt;

	pid_div_if div ();

	pid_divider u_div (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.div      (div.slave)
	);

	// ***************************************************************
	// Functions
	// ***************************************************************
	function automatic int src_index(input logic [7:0] sel);
		src_index = int'(sel[`PID_SEL_TYPE +: `PID_SEL_W]) * N_INST + int'(sel[`PID_SEL_NUM +: `PID_SEL_W]);
	endfunction

	function automatic logic src_ok(input logic [7:0] sel);
		src_ok = (int'(sel[`PID_SEL_TYPE +: `PID_SEL_W]) < N_TYPES) &&
		         (int'(sel[`PID_SEL_NUM +: `PID_SEL_W]) < N_INST);
	endfunction

	function automatic logic [47:0] pct_num(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] mn,
	                                        input logic [DATA_W-1:0] mx);
		logic [DATA_W-1:0] vc;
		vc = (v < mn) ? mn : ((v > mx) ? mx : v);
		pct_num = 48'(vc - mn) * 48'(`PID_PCT_FULL);
	endfunction

	function automatic logic [15:0] pct_den(input logic [DATA_W-1:0] mn, input logic [DATA_W-1:0] mx);
		pct_den = (mx > mn) ? 16'(mx - mn) : 16'h0000;
	endfunction

	// ***************************************************************
	// Source unpacking
	// ***************************************************************
	for (genvar g = 0; g < N_SRC; g++) begin : g_src
		assign vals[g] = i_src_value[g*DATA_W +: DATA_W];
		assign mins[g] = i_src_min[g*DATA_W +: DATA_W];
		assign maxs[g] = i_src_max[g*DATA_W +: DATA_W];
	end

	// ***************************************************************
	// Register writes
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			active_r  <= 1'b0;
			profile_r <= pid_pkg::PROF_SINGLE;
			loop_r    <= `PID_RST_LOOP;
			gain_r    <= `PID_RST_GAIN;
			ifact_r   <= `PID_RST_ZERO;
			itime_r   <= `PID_RST_ZERO;
			dfact_r   <= `PID_RST_ZERO;
			dtime_r   <= `PID_RST_ZERO;
			dband_r   <= `PID_RST_ZERO;
			tsel_r    <= 8'h00;
			fsel_r    <= 8'h00;
			osel_r    <= 8'h00;
		end else if (i_wr) begin
			unique case (i_addr)
				`PID_OFS_CTRL: begin
					active_r  <= i_wdata[`PID_CTRL_ACTIVE];
					profile_r <= pid_pkg::profile_t'(i_wdata[`PID_CTRL_PROF +: 2]);
				end
				`PID_OFS_LOOP:  loop_r  <= i_wdata[15:0];
				`PID_OFS_GAIN:  gain_r  <= i_wdata[15:0];
				`PID_OFS_IFACT: ifact_r <= i_wdata[15:0];
				`PID_OFS_ITIME: itime_r <= i_wdata[15:0];
				`PID_OFS_DFACT: dfact_r <= i_wdata[15:0];
				`PID_OFS_DTIME: dtime_r <= i_wdata[15:0];
				`PID_OFS_DBAND: dband_r <= i_wdata[15:0];
				`PID_OFS_TSEL:  tsel_r  <= i_wdata[7:0];
				`PID_OFS_FSEL:  fsel_r  <= i_wdata[7:0];
				`PID_OFS_OSEL:  osel_r  <= i_wdata[7:0];
				default: ;
			endcase
		end
	end

	// ***************************************************************
	// Register reads, data in the following cycle only
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rdata_r <= 32'h0;
		end else if (i_rd) begin
			unique case (i_addr)
				`PID_OFS_CTRL:  rdata_r <= {29'h0, profile_r, active_r};
				`PID_OFS_LOOP:  rdata_r <= {16'h0, loop_r};
				`PID_OFS_GAIN:  rdata_r <= {16'h0, gain_r};
				`PID_OFS_IFACT: rdata_r <= {16'h0, ifact_r};
				`PID_OFS_ITIME: rdata_r <= {16'h0, itime_r};
				`PID_OFS_DFACT: rdata_r <= {16'h0, dfact_r};
				`PID_OFS_DTIME: rdata_r <= {16'h0, dtime_r};
				`PID_OFS_DBAND: rdata_r <= {16'h0, dband_r};
				`PID_OFS_TSEL:  rdata_r <= {24'h0, tsel_r};
				`PID_OFS_FSEL:  rdata_r <= {24'h0, fsel_r};
				`PID_OFS_OSEL:  rdata_r <= {24'h0, osel_r};
				`PID_OFS_STAT:  rdata_r <= {iter_r, 14'h0, state_r != pid_pkg::ST_IDLE, active_r};
				`PID_OFS_CMD:   rdata_r <= 32'(cmd_r);
				`PID_OFS_ERR:   rdata_r <= 32'(prev_err_r);
				`PID_OFS_ACC:   rdata_r <= 32'(acc_r);
				default:        rdata_r <= 32'h0;
			endcase
		end else begin
			rdata_r <= 32'h0;
		end
	end

	assign o_rdata = rdata_r;

	// ***************************************************************
	// Loop period tick
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !active_r) begin
			cyc_r <= 32'h0;
			ms_r  <= 16'h0;
		end else if (cyc_r == 32'(CYC_PER_MS - 1)) begin
			cyc_r <= 32'h0;
			if (go) begin
				ms_r <= 16'h0;
			end else begin
				ms_r <= ms_r + 16'h0001;
			end
		end else begin
			cyc_r <= cyc_r + 32'h1;
		end
	end

	assign go = active_r && (cyc_r == 32'(CYC_PER_MS - 1)) &&
	            (ms_r + 16'h0001 >= ((loop_r == 16'h0) ? 16'h0001 : loop_r));

	// ***************************************************************
	// Iteration sequencer
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_r <= pid_pkg::ST_IDLE;
			step_r  <= 2'h0;
		end else begin
			unique case (state_r)
				pid_pkg::ST_IDLE: begin
					step_r <= 2'h0;
					if (go) begin
						state_r <= pid_pkg::ST_DIV;
					end
				end
				pid_pkg::ST_DIV: state_r <= pid_pkg::ST_WAIT;
				pid_pkg::ST_WAIT: begin
					if (div.done) begin
						if (step_r == 2'h3) begin
							state_r <= pid_pkg::ST_CALC;
						end else begin
							step_r  <= step_r + 2'h1;
							state_r <= pid_pkg::ST_DIV;
						end
					end
				end
				pid_pkg::ST_CALC: state_r <= pid_pkg::ST_IDLE;
			endcase
		end
	end

	// ***************************************************************
	// Divider operands
	// ***************************************************************
	always_comb begin
		op_num = 48'h0;
		op_den = 16'h0;
		unique case (step_r)
			2'h0: begin
				if (src_ok(tsel_r)) begin
					op_num = pct_num(vals[src_index(tsel_r)], mins[src_index(tsel_r)], maxs[src_index(tsel_r)]);
					op_den = pct_den(mins[src_index(tsel_r)], maxs[src_index(tsel_r)]);
				end
			end
			2'h1: begin
				if (src_ok(fsel_r)) begin
					op_num = pct_num(vals[src_index(fsel_r)], mins[src_index(fsel_r)], maxs[src_index(fsel_r)]);
					op_den = pct_den(mins[src_index(fsel_r)], maxs[src_index(fsel_r)]);
				end
			end
			2'h2: begin
				op_num = (48'(gain_r) * 48'(ifact_r) * 48'(loop_r)) >> `PID_FRAC_BITS;
				op_den = itime_r;
			end
			2'h3: begin
				op_num = (48'(gain_r) * 48'(dfact_r) * 48'(dtime_r)) >> `PID_FRAC_BITS;
				op_den = loop_r;
			end
		endcase
	end

	assign div.start    = (state_r == pid_pkg::ST_DIV);
	assign div.dividend = op_num;
	assign div.divisor  = op_den;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			tpct_r <= 16'h0;
			fpct_r <= 16'h0;
			ig_r   <= 32'h0;
			dg_r   <= 32'h0;
		end else if (state_r == pid_pkg::ST_WAIT && div.done) begin
			unique case (step_r)
				2'h0: tpct_r <= div.quotient[15:0];
				2'h1: fpct_r <= div.quotient[15:0];
				2'h2: ig_r   <= div.quotient;
				2'h3: dg_r   <= div.quotient;
			endcase
		end
	end

	// ***************************************************************
	// Control law
	// ***************************************************************
	always_comb begin
		err_raw = $signed({1'b0, tpct_r}) - $signed({1'b0, fpct_r});
		err_abs = err_raw[16] ? 17'(-err_raw) : 17'(err_raw);
		err_k   = ((dband_r != 16'h0) && (err_abs < {1'b0, dband_r})) ? 17'sh0 : err_raw;
		acc_sum = 25'(acc_r) + 25'(err_k);
		if (acc_sum > 25'sh07FFFFF) begin
			acc_nxt = 24'sh7FFFFF;
		end else if (acc_sum < -25'sh0800000) begin
			acc_nxt = -24'sh800000;
		end else begin
			acc_nxt = acc_sum[23:0];
		end
		p_term = $signed({1'b0, gain_r}) * err_k;
		i_term = $signed({1'b0, ig_r}) * acc_nxt;
		d_term = $signed({1'b0, dg_r}) * (err_k - prev_err_r);
		sum    = (p_term + i_term + d_term) >>> `PID_FRAC_BITS;
		unique case (profile_r)
			pid_pkg::PROF_SINGLE: begin
				cmd_nxt = (sum > PCT_HI) ? PCT_HI[15:0] : ((sum < PCT_LO) ? PCT_LO[15:0] : sum[15:0]);
			end
			pid_pkg::PROF_SETPOINT: begin
				cmd_nxt = (sum > PCT_HI) ? PCT_HI[15:0] : ((sum < 64'sh0) ? 16'sh0 : sum[15:0]);
			end
			pid_pkg::PROF_OVER:  cmd_nxt = (fpct_r > tpct_r) ? PCT_HI[15:0] : 16'sh0;
			pid_pkg::PROF_BELOW: cmd_nxt = (fpct_r < tpct_r) ? PCT_HI[15:0] : 16'sh0;
		endcase
	end

	// ***************************************************************
	// Controller state
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		active_d_r <= i_resetn && active_r;
		if (!i_resetn || (active_r && !active_d_r)) begin
			acc_r      <= 24'sh0;
			prev_err_r <= 17'sh0;
		end else if (state_r == pid_pkg::ST_CALC) begin
			acc_r      <= acc_nxt;
			prev_err_r <= err_k;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			cmd_r   <= 16'sh0;
			valid_r <= 1'b0;
			iter_r  <= 16'h0;
		end else begin
			valid_r <= (state_r == pid_pkg::ST_CALC);
			if (state_r == pid_pkg::ST_CALC) begin
				cmd_r  <= cmd_nxt;
				iter_r <= iter_r + 16'h0001;
			end
		end
	end

	// ***************************************************************
	// Physical output drive
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			sel_r   <= 1'b0;
			drive_r <= 16'sh0;
		end else begin
			sel_r   <= (int'(osel_r[`PID_SEL_TYPE +: `PID_SEL_W]) == PID_TYPE) &&
			           (int'(osel_r[`PID_SEL_NUM +: `PID_SEL_W]) == INSTANCE);
			drive_r <= sel_r ? cmd_r : 16'sh0;
		end
	end

	assign o_cmd          = cmd_r;
	assign o_cmd_valid    = valid_r;
	assign o_out_drive    = drive_r;
	assign o_out_selected = sel_r;

endmodule

/* logic/pid_defs.svh */
// Offsets, field positions, reset values and timing counts of the PID controller block.
// Assumes a 125 MHz system clock and a word-aligned register port.
`ifndef PID_DEFS_SVH
`define PID_DEFS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define PID_OFS_CTRL     8'h00
`define PID_OFS_LOOP     8'h04
`define PID_OFS_GAIN     8'h08
`define PID_OFS_IFACT    8'h0C
`define PID_OFS_ITIME    8'h10
`define PID_OFS_DFACT    8'h14
`define PID_OFS_DTIME    8'h18
`define PID_OFS_DBAND    8'h1C
`define PID_OFS_TSEL     8'h20
`define PID_OFS_FSEL     8'h24
`define PID_OFS_OSEL     8'h28
`define PID_OFS_STAT     8'h2C
`define PID_OFS_CMD      8'h30
`define PID_OFS_ERR      8'h34
`define PID_OFS_ACC      8'h38

// ***************************************************************
// Field positions
// ***************************************************************
`define PID_CTRL_ACTIVE  0
`define PID_CTRL_PROF    1
`define PID_SEL_NUM      0
`define PID_SEL_TYPE     4
`define PID_SEL_W        4

// ***************************************************************
// Reset values and scaling
// ***************************************************************
`define PID_RST_ZERO     16'h0000
`define PID_RST_LOOP     16'h000A
`define PID_RST_GAIN     16'h0100
`define PID_PCT_FULL     16'h2710
`define PID_FRAC_BITS    8

// ***************************************************************
// Timing
// ***************************************************************
`define PID_CLK_PERIOD_NS 8
`define PID_MS_NS         1000000
`define PID_DIV_STEPS     6'h30

`endif

/* logic/pid_div_if.sv */
// Request and answer signals between the PID controller and its divider.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface pid_div_if;
	logic        start;
	logic [47:0] dividend;
	logic [15:0] divisor;
	logic        done;
	logic [31:0] quotient;

	modport master (output start, output dividend, output divisor, input done, input quotient);
	modport slave  (input start, input dividend, input divisor, output done, output quotient);
endinterface

/* logic/pid_divider.sv */
// Sequential unsigned divider, one quotient bit per clock.
// Assumes start is raised only while no division is running.
`timescale 1ns/1ps
`include "pid_defs.svh"

module pid_divider (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	pid_div_if.slave  div
);

	logic [47:0] quo_r;
	logic [15:0] rem_r;
	logic [15:0] dsr_r;
	logic [5:0]  cnt_r;
	logic        busy_r;
	logic        done_r;
	logic [16:0] trial;

	assign trial = {rem_r, quo_r[47]} - {1'b0, dsr_r};

	// ***************************************************************
	// Shift and subtract
	// ***************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			quo_r  <= 48'h0;
			rem_r  <= 16'h0;
			dsr_r  <= 16'h0;
			cnt_r  <= 6'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= busy_r && (cnt_r == 6'h01);
			if (div.start && !busy_r) begin
				quo_r  <= div.dividend;
				rem_r  <= 16'h0;
				dsr_r  <= div.divisor;
				cnt_r  <= `PID_DIV_STEPS;
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (trial[16]) begin
					rem_r <= {rem_r[14:0], quo_r[47]};
					quo_r <= {quo_r[46:0], 1'b0};
				end else begin
					rem_r <= trial[15:0];
					quo_r <= {quo_r[46:0], 1'b1};
				end
				cnt_r <= cnt_r - 6'h01;
				if (cnt_r == 6'h01) begin
					busy_r <= 1'b0;
				end
			end
		end
	end

	// ***************************************************************
	// Answer, saturated, zero for a zero divisor
	// ***************************************************************
	assign div.done     = done_r;
	assign div.quotient = (dsr_r == 16'h0) ? 32'h0 : ((|quo_r[47:32]) ? 32'hFFFFFFFF : quo_r[31:0]);

endmodule

/* logic/pid_pkg.sv */
// Types used by the PID controller block; the divider does not use them.
// Assumes nothing beyond a SystemVerilog compiler.
package pid_pkg;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [1:0] {
		PROF_SINGLE,
		PROF_SETPOINT,
		PROF_OVER,
		PROF_BELOW
	} profile_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DIV,
		ST_WAIT,
		ST_CALC
	} state_t;

endpackage

/* verification/pid_control_block_tb_top.sv */
// Self-checking bench for the PID controller block.
// Assumes the source model feeds target and feedback and the register port is driven here.
`timescale 1ns/1ps

module pid_control_block_tb_top;
	// ***************************************************************
	// Signals
	// ***************************************************************
	logic               i_clk;
	logic               i_resetn;
	logic [7:0]         i_addr;
	logic [31:0]        i_wdata;
	logic               i_wr;
	logic               i_rd;
	logic [31:0]        o_rdata;
	logic signed [15:0] o_cmd;
	logic               o_cmd_valid;
	logic signed [15:0] o_out_drive;
	logic               o_out_selected;
	logic [255:0]       sv;
	logic [255:0]       smin;
	logic [255:0]       smax;
	int                 error_cnt;
	int                 checks_done;
	logic [15:0]        prof_exp [4] = '{16'h09C4, 16'h09C4, 16'h0000, 16'h2710};

	pid_control_block #(.CYC_PER_MS(300)) DUT (
		.i_clk (i_clk), .i_resetn (i_resetn), .i_addr (i_addr), .i_wdata (i_wdata),
		.i_wr (i_wr), .i_rd (i_rd), .o_rdata (o_rdata), .i_src_value (sv),
		.i_src_min (smin), .i_src_max (smax), .o_cmd (o_cmd), .o_cmd_valid (o_cmd_valid),
		.o_out_drive (o_out_drive), .o_out_selected (o_out_selected)
	);

	pid_source_model src (.i_clk (i_clk), .o_value (sv), .o_min (smin), .o_max (smax));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ***************************************************************
	// Tasks
	// ***************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(o_rdata, exp);
	endtask

	// Waits for the next iteration, checks the command and the driven output a cycle later
	task automatic cmd_chk(input logic [15:0] exp);
		int k;
		k = 0;
		do begin
			@(negedge i_clk);
			k++;
		end while (o_cmd_valid !== 1'b1 && k < 1000);
		chk({31'h0, o_cmd_valid}, 32'h1);
		chk({{16{o_cmd[15]}}, o_cmd}, {{16{exp[15]}}, exp});
		@(negedge i_clk);
		chk({{16{o_out_drive[15]}}, o_out_drive}, {{16{exp[15]}}, exp});
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#(30000 * 8);
		error_cnt++;
		give_verdict();
	end

	// ***************************************************************
	// Tests
	// ***************************************************************
	initial begin
		i_resetn    = 1'b0;
		i_wr        = 1'b0;
		i_rd        = 1'b0;
		i_addr      = 8'h00;
		i_wdata     = 32'h0;
		error_cnt   = 0;
		checks_done = 0;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0000000A);
		rdc(8'h08, 32'h00000100);
		wr(8'h40, 32'hFFFFFFFF);
		rdc(8'h40, 32'h0);
		src.set_src(6, 16'h0032, 16'h0000, 16'h0064);
		src.set_src(11, 16'h00C8, 16'h0064, 16'h01F4);
		wr(8'h04, 32'h1);
		wr(8'h20, 32'h12);
		wr(8'h24, 32'h23);
		wr(8'h28, 32'h50);
		rdc(8'h20, 32'h12);
		for (int p = 0; p < 4; p++) begin
			wr(8'h00, 32'(p * 2 + 1));
			cmd_chk(prof_exp[p]);
			if (p == 0) begin
				cmd_chk(16'h09C4);
				rdc(8'h38, 32'h1388);
				rdc(8'h34, 32'h09C4);
				rdc(8'h30, 32'h09C4);
				rdc(8'h2C, 32'h00020001);
			end
			if (p == 1)
				rdc(8'h38, 32'h09C4);
			wr(8'h00, 32'h0);
		end
		wr(8'h1C, 32'h0BB8);
		wr(8'h00, 32'h1);
		cmd_chk(16'h0000);
		wr(8'h00, 32'h0);
		wr(8'h1C, 32'h09C4);
		wr(8'h00, 32'h1);
		cmd_chk(16'h09C4);
		wr(8'h00, 32'h0);
		wr(8'h1C, 32'h0);
		wr(8'h08, 32'h0500);
		src.set_src(11, 16'h01F4, 16'h0064, 16'h01F4);
		wr(8'h00, 32'h1);
		cmd_chk(16'hD8F0);
		wr(8'h00, 32'h3);
		cmd_chk(16'h0000);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h0100);
		src.set_src(11, 16'h00C8, 16'h0064, 16'h01F4);
		wr(8'h0C, 32'h0100);
		wr(8'h10, 32'h1);
		wr(8'h00, 32'h1);
		cmd_chk(16'h1388);
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h0);
		wr(8'h00, 32'h1);
		cmd_chk(16'h09C4);
		wr(8'h00, 32'h0);
		wr(8'h0C, 32'h0);
		wr(8'h14, 32'h0100);
		wr(8'h18, 32'h1);
		wr(8'h00, 32'h1);
		cmd_chk(16'h1388);
		cmd_chk(16'h09C4);
		wr(8'h00, 32'h0);
		give_verdict();
	end
endmodule

/* verification/pid_control_chk.sv */
// Concurrent checks on the ports of the PID controller block.
// Assumes one clock domain and a synchronous active-low reset; bound at the foot of this file.
`timescale 1ns/1ps

module pid_control_chk #(
	parameter int CYC_PER_MS = 300,
	parameter int PID_TYPE   = 5,
	parameter int INSTANCE   = 0
) (
	input wire logic               i_clk,
	input wire logic               i_resetn,
	input wire logic [7:0]         i_addr,
	input wire logic [31:0]        i_wdata,
	input wire logic               i_wr,
	input wire logic               i_rd,
	input wire logic [31:0]        o_rdata,
	input wire logic signed [15:0] o_cmd,
	input wire logic               o_cmd_valid,
	input wire logic signed [15:0] o_out_drive,
	input wire logic               o_out_selected
);
	// ***************************************************************
	// Helper state
	// ***************************************************************
	localparam logic [7:0] SEL = 8'(PID_TYPE * 16 + INSTANCE);
	logic [2:0]  ctrl_r;
	logic [15:0] lp_r;
	logic        seen_r;
	int          gap_r;
	int          per;

	assign per = ((lp_r == 16'h0000) ? 1 : int'(lp_r)) * CYC_PER_MS;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ctrl_r <= 3'h0;
			lp_r   <= 16'h000A;
		end else if (i_wr && i_addr == 8'h00) begin
			ctrl_r <= i_wdata[2:0];
		end else if (i_wr && i_addr == 8'h04) begin
			lp_r <= i_wdata[15:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn || i_wr) begin
			seen_r <= 1'b0;
		end else if (o_cmd_valid) begin
			seen_r <= 1'b1;
		end
		gap_r <= o_cmd_valid ? 1 : gap_r + 1;
	end

	// ***************************************************************
	// Assertions
	// ***************************************************************
	loop_gap_a: assert property (o_cmd_valid && seen_r |-> gap_r == per)
		else $error("iteration spacing differs from loop period");
	valid_pulse_a: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("command valid longer than one cycle");
	onoff_level_a: assert property (o_cmd_valid && ctrl_r[2] |-> o_cmd == 16'sh0000 || o_cmd == 16'sh2710)
		else $error("on/off profile gave a level other than 0 or full");
	setpoint_pos_a: assert property (o_cmd_valid && ctrl_r[2:1] == 2'b01 |-> !o_cmd[15])
		else $error("setpoint profile gave a negative command");
	cmd_span_a: assert property (o_cmd >= 16'shD8F0 && o_cmd <= 16'sh2710)
		else $error("command outside plus or minus full scale");
	cmd_hold_a: assert property (!$stable(o_cmd) |-> o_cmd_valid)
		else $error("command changed without valid pulse");
	drive_follow_a: assert property (o_out_selected && $past(o_out_selected) |-> o_out_drive == $past(o_cmd))
		else $error("output drive does not follow command");
	drive_off_a: assert property (!o_out_selected && !$past(o_out_selected) |-> o_out_drive == 16'sh0000)
		else $error("unselected output is driven");
	sel_match_a: assert property (i_wr && i_addr == 8'h28 && i_wdata[7:0] == SEL |-> ##2 o_out_selected)
		else $error("matching output source not selected");

	cover property (o_cmd_valid && o_out_selected);
	cover property (o_cmd_valid && ctrl_r[2:1] == 2'b11);
	cover property (o_cmd_valid && o_cmd == 16'sh0000);
endmodule

bind pid_control_block pid_control_chk #(
	.CYC_PER_MS (CYC_PER_MS),
	.PID_TYPE   (PID_TYPE),
	.INSTANCE   (INSTANCE)
) chk_i (
	.i_clk          (i_clk),
	.i_resetn       (i_resetn),
	.i_addr         (i_addr),
	.i_wdata        (i_wdata),
	.i_wr           (i_wr),
	.i_rd           (i_rd),
	.o_rdata        (o_rdata),
	.o_cmd          (o_cmd),
	.o_cmd_valid    (o_cmd_valid),
	.o_out_drive    (o_out_drive),
	.o_out_selected (o_out_selected)
);

/* verification/pid_source_model.sv */
// Model of the source blocks that feed the controller: one value and its range per source.
// Assumes the bench sets sources through set_src and shares the controller clock.
`timescale 1ns/1ps

module pid_source_model #(
	parameter int N = 16,
	parameter int W = 16
) (
	input  wire logic         i_clk,
	output logic [N*W-1:0]    o_value,
	output logic [N*W-1:0]    o_min,
	output logic [N*W-1:0]    o_max
);
	// ***************************************************************
	// Source values and range limits
	// ***************************************************************
	initial begin
		o_value = '0;
		o_min   = '0;
		o_max   = '0;
	end

	// Each source updates after a clock edge, laid out by type and number
	task automatic set_src(input int idx, input logic [15:0] v, input logic [15:0] mn, input logic [15:0] mx);
		@(posedge i_clk);
		o_value[idx*W +: W] <= v;
		o_min[idx*W +: W]   <= mn;
		o_max[idx*W +: W]   <= mx;
	endtask
endmodule
